// [inc/tmr8_params.svh]
// register offsets, field positions, reset values and timing counts of the timer block
`ifndef TMR8_PARAMS_SVH
`define TMR8_PARAMS_SVH
// printed offsets are not all multiples of four: they are indices, byte address is index*4
`define IDX_TIMER_COUNT    8'h01
`define IDX_INTR_CONTROL   8'h0B
`define IDX_OPTION_CONFIG  8'h81
`define IDX_EVENT_STATUS   8'hA0
`define IDX_EVENT_MASK     8'hA1
`define IDX_CONTROL        8'hA2
// interrupt control bits
`define IC_GIE             7
`define IC_OVF_IE          5
`define IC_OVF_FLAG        2
`define IC_RESET           8'h00
`define IC_WMASK           8'hFB
// option config bits
`define OPT_SRC            5
`define OPT_EDGE           4
`define OPT_ASSIGN         3
`define OPT_RATE_HI        2
`define OPT_RESET          8'hFF
// control register bits
`define CTL_SLEEP          0
`define CTL_WDT_CLEAR      1
// event bits
`define EV_OVERFLOW        0
`define EV_COUNT_WRITE     1
`define EV_WIDTH           2
// timing
`define PHASES_PER_CYCLE   4
`define INHIBIT_CYCLES     2'd2
`define COUNT_RESET        8'h00
`endif

// [inc/tmr8_pkg.sv]
// types of the eight-bit timer block
package tmr8_pkg;
	typedef struct packed {
		logic       src_ext;
		logic       edge_fall;
		logic       assign_wdt;
		logic [2:0] rate;
	} option_t;
	typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_t;
endpackage

// [core/tmr8_timer.sv]
// eight-bit timer/counter with shared divider and apb register access
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "tmr8_params.svh"
// Summary of operation
// - source clear: count instruction cycles
// - count write blocks increments for two instruction cycles
// - source set: count selected pin edge
// - wrap from all ones sets flag
// - flag requests interrupt only when enabled
// - flag sticky until software clears it
// - timer halted during sleep
// - undivided: pin passes straight through
// - divider output sampled on phases two, four
// - assign bit routes divider timer or watchdog
// - rate code picks power-of-two ratio
// - divider eight bits, not software visible
// - count write clears divider when assigned
// - watchdog clear clears divider when assigned
// - overflow request needs global enable
module tmr8_timer
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_count_input,
	output logic             irq,
	output logic             overflow_irq_req,
	output logic             wdt_divided_tick,
	input  wire logic        wdt_raw_tick
);
	logic [7:0]  timer_count_value_r;
	logic [7:0]  interrupt_control_r;
	logic [7:0]  timer_option_config_r;
	logic [7:0]  divider_r;
	logic [1:0]  inhibit_r;
	logic [1:0]  phase_r;
	logic        pin_s1_r;
	logic        pin_s2_r;
	logic        pin_q4_r;
	logic        div_q2_r;
	logic        div_q4_r;
	logic        sleep_r;
	logic [`EV_WIDTH-1:0] status_r;
	logic [`EV_WIDTH-1:0] mask_r;
	logic        wdt_prev_r;
	tmr8_pkg::option_t opt;
	logic        wr;
	logic        rd;
	logic [9:0]  idx;
	logic        count_wr;
	logic        wdt_clear;
	logic        cyc_tick;
	logic        q2;
	logic        q4;
	logic        pin_edge;
	logic        src_tick;
	logic [7:0]  div_nxt;
	logic        div_out;
	logic        timer_tick;
	logic        wdt_div_out;
	logic        incr;
	logic        wrap;
	logic [7:0]  rdata_nxt;

	// tap of the divider for a rate code; base is 1 for the timer, 0 for the watchdog
	function automatic logic div_tap(input logic [7:0] d, input logic [2:0] rate, input logic base);
		logic [3:0] bitpos;
		bitpos = {1'b0, rate} + {3'b000, base};
		div_tap = (bitpos == 4'h0) ? 1'b1 : d[3'(bitpos - 4'h1)];
	endfunction

	assign opt = tmr8_pkg::option_t'(timer_option_config_r[`OPT_SRC:0]);
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign idx = paddr[11:2];
	assign count_wr = wr && (idx == {2'b00, `IDX_TIMER_COUNT});
	assign wdt_clear = wr && (idx == {2'b00, `IDX_CONTROL}) && pwdata[`CTL_WDT_CLEAR];

	// four-phase instruction cycle from pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_r <= 2'h0;
		else
			phase_r <= phase_r + 2'h1;
	end
	assign q2 = (phase_r == 2'(tmr8_pkg::Q2));
	assign q4 = (phase_r == 2'(tmr8_pkg::Q4));
	assign cyc_tick = q4;

	// pin synchroniser, first stage read only by the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
		end
		else
		begin
			pin_s1_r <= ext_count_input;
			pin_s2_r <= pin_s1_r;
		end
	end

	// pin level at the last Q4, so each pin edge is seen at one Q4 only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_q4_r <= 1'b0;
		else if (q4)
			pin_q4_r <= pin_s2_r;
	end

	// source edge: external with polarity, or instruction cycle
	assign pin_edge = (pin_s2_r ^ opt.edge_fall) && !(pin_q4_r ^ opt.edge_fall);
	assign src_tick = opt.src_ext ? pin_edge && q4 : cyc_tick;

	// divider clock: timer source or watchdog tick
	assign wdt_div_out = div_tap(divider_r, opt.rate, 1'b0);
	always_comb
	begin
		div_nxt = divider_r;
		if (opt.assign_wdt ? wdt_raw_tick && !wdt_prev_r : src_tick && !sleep_r)
			div_nxt = divider_r + 8'h01;
	end

	// shared hidden divider, cleared by count write or watchdog clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			divider_r <= 8'h00;
		else if ((count_wr && !opt.assign_wdt) || (wdt_clear && opt.assign_wdt))
			divider_r <= 8'h00;
		else
			divider_r <= div_nxt;
	end

	// divider output: straight pin level when unassigned with external source, zero with internal source, tap otherwise
	assign div_out = opt.assign_wdt
		? (opt.src_ext ? pin_s2_r : 1'b0)
		: div_tap(divider_r, opt.rate, 1'b1);

	// sample divider output on phases two and four
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_q2_r <= 1'b0;
			div_q4_r <= 1'b0;
		end
		else
		begin
			if (q2)
				div_q2_r <= div_out;
			if (q4)
				div_q4_r <= div_q2_r;
		end
	end

	// timer tick: rising of synchronised divider output or direct source
	assign timer_tick = opt.assign_wdt ? src_tick
		: q4 && div_q2_r && !div_q4_r;
	assign incr = timer_tick && !sleep_r && !count_wr && (inhibit_r == 2'h0);
	assign wrap = incr && (timer_count_value_r == 8'hFF);

	// post-write inhibit counted in instruction cycles
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			inhibit_r <= 2'h0;
		else if (count_wr)
			inhibit_r <= `INHIBIT_CYCLES;
		else if (cyc_tick && inhibit_r != 2'h0)
			inhibit_r <= inhibit_r - 2'h1;
	end

	// count register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_count_value_r <= `COUNT_RESET;
		else if (count_wr)
			timer_count_value_r <= pwdata[7:0];
		else if (incr)
			timer_count_value_r <= timer_count_value_r + 8'h01;
	end

	// interrupt control; overflow set wins over software clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			interrupt_control_r <= `IC_RESET;
		else
		begin
			if (wr && idx == {2'b00, `IDX_INTR_CONTROL})
				interrupt_control_r <= pwdata[7:0];
			if (wrap)
				interrupt_control_r[`IC_OVF_FLAG] <= 1'b1;
		end
	end

	// option configuration and sleep control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_option_config_r <= `OPT_RESET;
			sleep_r <= 1'b0;
			wdt_prev_r <= 1'b0;
		end
		else
		begin
			wdt_prev_r <= wdt_raw_tick;
			if (wr && idx == {2'b00, `IDX_OPTION_CONFIG})
				timer_option_config_r <= pwdata[7:0];
			if (wr && idx == {2'b00, `IDX_CONTROL})
				sleep_r <= pwdata[`CTL_SLEEP];
		end
	end

	// event status, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_r <= '0;
			mask_r <= '0;
		end
		else
		begin
			if (wr && idx == {2'b00, `IDX_EVENT_MASK})
				mask_r <= pwdata[`EV_WIDTH-1:0];
			status_r <= (status_r & ~((wr && idx == {2'b00, `IDX_EVENT_STATUS})
				? pwdata[`EV_WIDTH-1:0] : '0))
				| {count_wr, wrap};
		end
	end

	// outputs registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			overflow_irq_req <= 1'b0;
			irq <= 1'b0;
			wdt_divided_tick <= 1'b0;
		end
		else
		begin
			overflow_irq_req <= interrupt_control_r[`IC_GIE]
				&& interrupt_control_r[`IC_OVF_IE]
				&& interrupt_control_r[`IC_OVF_FLAG];
			irq <= |(status_r & mask_r);
			wdt_divided_tick <= opt.assign_wdt ? wdt_div_out && wdt_raw_tick && !wdt_prev_r
				: wdt_raw_tick && !wdt_prev_r;
		end
	end

	// read mux, address decode
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (idx == {2'b00, `IDX_TIMER_COUNT})
			rdata_nxt = timer_count_value_r;
		else if (idx == {2'b00, `IDX_INTR_CONTROL})
			rdata_nxt = interrupt_control_r;
		else if (idx == {2'b00, `IDX_OPTION_CONFIG})
			rdata_nxt = timer_option_config_r;
		else if (idx == {2'b00, `IDX_EVENT_STATUS})
			rdata_nxt = {6'h00, status_r};
		else if (idx == {2'b00, `IDX_EVENT_MASK})
			rdata_nxt = {6'h00, mask_r};
		else if (idx == {2'b00, `IDX_CONTROL})
			rdata_nxt = {7'h00, sleep_r};
	end

	// apb answer: zero-wait access, read data captured in setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (rd)
				prdata <= {24'h000000, rdata_nxt};
		end
	end

	// no count while sleeping
	sleep_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_r && !count_wr |=> $stable(timer_count_value_r))
		else $error("count moved during sleep");
	// write blocks two cycles of counting
	write_inhibit_a: assert property (@(posedge pclk) disable iff (!presetn)
		count_wr |=> (inhibit_r == 2'h2))
		else $error("inhibit not loaded");
	// wrap sets flag
	wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		wrap |=> interrupt_control_r[`IC_OVF_FLAG] && timer_count_value_r == 8'h00)
		else $error("wrap without flag");
	// request needs overflow enable
	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		overflow_irq_req |-> $past(interrupt_control_r[`IC_OVF_IE]))
		else $error("request without enable");
	// global gate
	global_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		!interrupt_control_r[`IC_GIE] |=> !overflow_irq_req)
		else $error("request without global enable");
	// flag sticky
	flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		interrupt_control_r[`IC_OVF_FLAG] && !wr |=> interrupt_control_r[`IC_OVF_FLAG])
		else $error("flag dropped");
	// divider cleared by count write when timer-assigned
	div_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		count_wr && !opt.assign_wdt |=> divider_r == 8'h00)
		else $error("divider not cleared");
	// watchdog clear
	wdt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		wdt_clear && opt.assign_wdt |=> divider_r == 8'h00)
		else $error("divider not cleared by watchdog clear");
	// instruction cycle of four phases
	phase_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
		q4 |-> ##4 q4)
		else $error("phase cycle not four");
endmodule

// [tb/ext_source.sv]
// count pin and watchdog tick source facing the timer
`timescale 1ns/1ps
module ext_source
(
	input  wire logic pclk,
	output logic      ext_count_input,
	output logic      wdt_raw_tick
);
	// pin idles low between pulses
	initial
	begin
		ext_count_input = 1'b0;
		wdt_raw_tick = 1'b0;
	end
	// whole pulses, each level held ten clocks so the phase sampler sees it
	task automatic pulse_pin(input int n);
		repeat (n)
		begin
			repeat (10) @(posedge pclk);
			ext_count_input <= 1'b1;
			repeat (10) @(posedge pclk);
			ext_count_input <= 1'b0;
		end
	endtask
	// watchdog ticks, one rising edge each
	task automatic wdt_ticks(input int n);
		repeat (n)
		begin
			repeat (6) @(posedge pclk);
			wdt_raw_tick <= 1'b1;
			repeat (6) @(posedge pclk);
			wdt_raw_tick <= 1'b0;
		end
	endtask
endmodule

// [tb/eight_bit_timer_shared_prescaler_test.sv]
// self-checking bench for the eight-bit timer
`timescale 1ns/1ps
`include "tmr8_params.svh"
module eight_bit_timer_shared_prescaler_test;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [31:0] r1;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        irq;
	logic        ovf_req;
	logic        wdt_out;
	logic        pin;
	logic        wdt_in;
	int          fails;
	int          n_compared;
	int          n_div;
	int          n_base;
	int          i;

	tmr8_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_count_input(pin), .irq(irq), .overflow_irq_req(ovf_req),
		.wdt_divided_tick(wdt_out), .wdt_raw_tick(wdt_in));
	ext_source src (.pclk(pclk), .ext_count_input(pin), .wdt_raw_tick(wdt_in));

	// clock, 25 ns period
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// count divided watchdog pulses
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			n_div <= 0;
		else if (wdt_out === 1'b1)
			n_div <= n_div + 1;

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, byte address is index times four
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20)
		begin
			fails++;
			close_out();
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, {24'h000000, d});
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 32'h00000000);
		check(rd, {24'h000000, exp});
	endtask
	// counts gained between two reads gap+3 clocks apart
	task automatic span(input int gap, input logic [7:0] exp);
		xfer(1'b0, `IDX_TIMER_COUNT, 32'h00000000);
		r1 = rd;
		repeat (gap) @(posedge pclk);
		xfer(1'b0, `IDX_TIMER_COUNT, 32'h00000000);
		check({24'h000000, rd[7:0] - r1[7:0]}, {24'h000000, exp});
	endtask

	// main sequence
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		fails = 0;
		n_compared = 0;
		n_base = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(`IDX_OPTION_CONFIG, 8'hFF);
		rdchk(`IDX_INTR_CONTROL, 8'h00);
		rdchk(8'h55, 8'h00);
		check({31'd0, err}, 32'h0);
		wr(`IDX_OPTION_CONFIG, 8'h08);
		span(397, 8'd100);
		wr(`IDX_CONTROL, 8'h02);
		for (i = 0; i < 3; i++)
		begin
			wr(`IDX_OPTION_CONFIG, 8'(i));
			// let a tap switch settle before the measured window
			repeat (8) @(posedge pclk);
			span(797, 8'(100 >> i));
		end
		wr(`IDX_CONTROL, 8'h01);
		span(397, 8'd0);
		wr(`IDX_CONTROL, 8'h00);
		wr(`IDX_OPTION_CONFIG, 8'h08);
		wr(`IDX_TIMER_COUNT, 8'h10);
		// forty clocks after the write: ten cycles, two of them lost
		repeat (39) @(posedge pclk);
		rdchk(`IDX_TIMER_COUNT, 8'h18);
		// overflow with the request held back, then passed on
		wr(`IDX_INTR_CONTROL, 8'h20);
		wr(`IDX_TIMER_COUNT, 8'hFE);
		repeat (40) @(posedge pclk);
		rdchk(`IDX_INTR_CONTROL, 8'h24);
		check({31'd0, ovf_req}, 32'h0);
		wr(`IDX_INTR_CONTROL, 8'hA0);
		rdchk(`IDX_INTR_CONTROL, 8'hA0);
		wr(`IDX_EVENT_MASK, 8'h01);
		wr(`IDX_TIMER_COUNT, 8'hFE);
		for (i = 0; i < 100 && ovf_req !== 1'b1; i++)
			@(posedge pclk);
		@(posedge pclk);
		check({31'd0, ovf_req}, 32'h1);
		check({31'd0, irq}, 32'h1);
		rdchk(`IDX_EVENT_STATUS, 8'h03);
		wr(`IDX_EVENT_MASK, 8'h00);
		repeat (2) @(posedge pclk);
		check({31'd0, irq}, 32'h0);
		wr(`IDX_EVENT_STATUS, 8'h03);
		rdchk(`IDX_EVENT_STATUS, 8'h00);
		// external pin, rising then falling edges, then through the divider
		wr(`IDX_OPTION_CONFIG, 8'h28);
		wr(`IDX_TIMER_COUNT, 8'h00);
		src.pulse_pin(5);
		repeat (20) @(posedge pclk);
		rdchk(`IDX_TIMER_COUNT, 8'h05);
		wr(`IDX_OPTION_CONFIG, 8'h38);
		src.pulse_pin(3);
		repeat (20) @(posedge pclk);
		rdchk(`IDX_TIMER_COUNT, 8'h08);
		wr(`IDX_CONTROL, 8'h02);
		wr(`IDX_OPTION_CONFIG, 8'h20);
		wr(`IDX_TIMER_COUNT, 8'h00);
		src.pulse_pin(4);
		repeat (20) @(posedge pclk);
		rdchk(`IDX_TIMER_COUNT, 8'h02);
		// watchdog side: direct, then postscaled, then cleared mid-count
		n_base = n_div;
		src.wdt_ticks(3);
		repeat (6) @(posedge pclk);
		check(32'(n_div - n_base), 32'd3);
		// move the divider to the watchdog in the safe order
		wr(`IDX_CONTROL, 8'h02);
		wr(`IDX_TIMER_COUNT, 8'h00);
		wr(`IDX_OPTION_CONFIG, 8'h2F);
		wr(`IDX_CONTROL, 8'h02);
		wr(`IDX_OPTION_CONFIG, 8'h09);
		n_base = n_div;
		src.wdt_ticks(4);
		repeat (6) @(posedge pclk);
		check(32'(n_div - n_base), 32'd2);
		src.wdt_ticks(1);
		wr(`IDX_CONTROL, 8'h02);
		src.wdt_ticks(1);
		repeat (6) @(posedge pclk);
		check(32'(n_div - n_base), 32'd2);
		close_out();
	end
endmodule
